// >>> adc_sample_convert_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_sample_convert_sequencer_tb import adcs_pkg::*;;
	logic clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic ce = 1'b1;
	logic hw_trigger = 1'b0, pready, pslverr, irq, shs_sample, conv_start, conv_done;
	logic [ADDR_W-1:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [RES_W-1:0] conv_result, res_next;
	logic [3:0] lat;
	logic [31:0] expq[$];
	int errors = 0, comparisons = 0;
	always #50 clk = ~clk;
	adcs_top i_dut (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .shs_sample, .conv_start, .conv_done, .conv_result, .hw_trigger);
	adcs_core_model i_core (.clk, .arst_n, .conv_start, .lat, .res_next, .conv_done, .conv_result);
	task automatic compare(input logic [31:0] got, input logic [31:0] e);
		comparisons++;
		if (got !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, e);
		end
	endtask : compare
	task automatic compare_pin(input logic got, input logic e);
		comparisons++;
		if (got !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, e);
		end
	endtask : compare_pin
	task automatic give_verdict;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	// Read data goes to the queue as expectation
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) expq.push_back(d);
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wait_done;
		do @(posedge clk); while (conv_done !== 1'b1);
		@(posedge clk);
	endtask : wait_done
	task automatic fresh;
		res_next <= RES_W'($urandom);
		lat <= 4'(6 + $urandom % 4);
	endtask : fresh
	always @(posedge clk)
		if (psel && penable && pready && !pwrite && expq.size() > 0)
			compare(prdata, expq.pop_front());
	initial begin
		repeat (5000) @(posedge clk);
		errors++;
		give_verdict;
	end
	initial begin
		void'($urandom(32'h4f07fdb3));
		fresh;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		apb(0, OFF_CTRL, 32'h0);
		apb(0, OFF_SEQ, 32'h100);
		apb(0, OFF_STATUS, 32'h0);
		apb(0, OFF_CLEAR, 32'h0);
		apb(0, 8'h18, 32'h0);
		// Manual sampling ended by software
		apb(1, OFF_ENABLE, 32'h3);
		apb(1, OFF_CTRL, 32'h8002);
		apb(0, OFF_CTRL, 32'h8002);
		apb(1, OFF_CTRL, 32'h8000);
		wait_done;
		compare_pin(irq, 1'b1);
		apb(0, OFF_CTRL, 32'h8001);
		apb(0, OFF_RESULT, 32'(res_next));
		apb(1, OFF_STATUS, 32'h0);
		apb(0, OFF_STATUS, 32'h3);
		apb(1, OFF_ENABLE, 32'h0);
		@(posedge clk);
		compare_pin(irq, 1'b0);
		apb(1, OFF_ENABLE, 32'h3);
		apb(1, OFF_CLEAR, 32'h3);
		@(posedge clk);
		compare_pin(irq, 1'b0);
		apb(1, OFF_CTRL, 32'h8000);
		apb(0, OFF_CTRL, 32'h8000);
		apb(1, OFF_CTRL, 32'h8001);
		apb(0, OFF_CTRL, 32'h8000);
		// Auto sampling halted at first sequence end
		fresh;
		apb(1, OFF_CTRL, 32'h80f4);
		wait_done;
		repeat (8) @(posedge clk);
		compare_pin(shs_sample, 1'b0);
		apb(0, OFF_CTRL, 32'h80f1);
		// Free running, two conversions per sequence
		apb(1, OFF_SEQ, 32'h101);
		apb(1, OFF_CLEAR, 32'h3);
		apb(1, OFF_CTRL, 32'h80e4);
		wait_done;
		compare_pin(shs_sample, 1'b1);
		fresh;
		apb(0, OFF_CTRL, 32'h80e4);
		apb(0, OFF_STATUS, 32'h2);
		wait_done;
		apb(0, OFF_RESULT, 32'(res_next));
		apb(0, OFF_STATUS, 32'h3);
		apb(1, OFF_CTRL, 32'h0);
		repeat (12) @(posedge clk);
		// Hardware trigger ends sampling
		fresh;
		apb(1, OFF_CTRL, 32'h8022);
		repeat (6) @(posedge clk);
		compare_pin(shs_sample, 1'b1);
		// Trigger pulse while frozen must be ignored
		ce <= 1'b0;
		hw_trigger <= 1'b1;
		@(posedge clk);
		hw_trigger <= 1'b0;
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
		compare_pin(shs_sample, 1'b1);
		hw_trigger <= 1'b1;
		@(posedge clk);
		hw_trigger <= 1'b0;
		wait_done;
		apb(0, OFF_CTRL, 32'h8021);
		give_verdict;
	end
endmodule : adc_sample_convert_sequencer_tb
bind adcs_top adcs_checker i_chk (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .irq, .shs_sample, .conv_start, .conv_done, .conv_result,
	.hw_trigger);
`default_nettype wire

// >>> adcs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_checker import adcs_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq,
	input wire logic shs_sample,
	input wire logic conv_start,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_result,
	input wire logic hw_trigger
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire logic acc = psel && penable;
	wire logic wr_acc = acc && pwrite;
	wire logic sw_end = wr_acc && paddr == OFF_CTRL && pwdata[CTRL_ON] && !pwdata[CTRL_SAMPLE_FLAG];
	sequence launch_seq;
		!shs_sample && conv_start;
	endsequence
	ready_match_a: assert property (pready == acc) else $error("bad pready");
	slverr_scope_a: assert property (pslverr |-> acc) else $error("bad pslverr");
	hole_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("bad read");
	manual_end_a: assert property (
		shs_sample && sw_end && pwdata[7:5] == SRC_MANUAL |=> launch_seq) else $error("no launch");
	start_after_a: assert property (conv_start |-> $fell(shs_sample)) else $error("bad start");
	start_pulse_a: assert property (conv_start |=> !conv_start) else $error("long start");
	irq_cause_a: assert property (
		$rose(irq) |-> $past(conv_done) || $past(wr_acc)) else $error("stray irq");
	sample_cause_a: assert property (
		$rose(shs_sample) |-> $past(conv_done) || $past(wr_acc)) else $error("stray sample");
endmodule : adcs_checker
`default_nettype wire

// >>> adcs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_core_model import adcs_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic conv_start,
	input wire logic [3:0] lat,
	input wire logic [RES_W-1:0] res_next,
	output logic conv_done,
	output logic [RES_W-1:0] conv_result
);
	logic [3:0] cnt;
	logic busy;
	wire logic fin = busy && cnt == lat;
	// Result toggles while not valid
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			busy <= 1'b0;
			cnt <= 4'h0;
			conv_done <= 1'b0;
			conv_result <= '0;
		end else begin
			conv_done <= fin;
			conv_result <= fin ? res_next : ~conv_result;
			busy <= conv_start || (busy && !fin);
			cnt <= conv_start ? 4'h1 : cnt + 4'h1;
		end
	end
endmodule : adcs_core_model
`default_nettype wire

// >>> adcs_irq_if.sv
`timescale 1ns/1ps
`default_nettype none
interface adcs_irq_if;
	import adcs_pkg::*;
	logic [EVT_W-1:0] events;
	logic clr_we;
	logic en_we;
	logic [EVT_W-1:0] wdata;
	logic [EVT_W-1:0] status;
	logic [EVT_W-1:0] enable;
	logic irq;
	modport ctrl (output events, output clr_we, output en_we, output wdata,
		input status, input enable, input irq);
	modport unit (input events, input clr_we, input en_we, input wdata,
		output status, output enable, output irq);
endinterface : adcs_irq_if
`default_nettype wire

// >>> adcs_irq_unit.sv
`timescale 1ns/1ps
`default_nettype none
module adcs_irq_unit import adcs_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	adcs_irq_if.unit bus
);
	logic [EVT_W-1:0] status;
	logic [EVT_W-1:0] enable;

	// Sticky status, set wins over a clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < EVT_W; i++) begin : g_evt
			always_ff @(posedge clk or negedge arst_n) begin
				if (!arst_n) begin
					status[i] <= 1'b0;
				end else if (ce) begin
					if (bus.events[i]) begin
						status[i] <= 1'b1;
					end else if (bus.clr_we && bus.wdata[i]) begin
						status[i] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			enable <= RST_EVT;
		end else if (ce && bus.en_we) begin
			enable <= bus.wdata;
		end
	end

	assign bus.status = status;
	assign bus.enable = enable;
	assign bus.irq = |(status & enable);
endmodule : adcs_irq_unit
`default_nettype wire

// >>> adcs_pkg.sv
`default_nettype none
package adcs_pkg;
	localparam int ADDR_W = 8;
	localparam int RES_W = 10;
	localparam int EVT_W = 2;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_SEQ = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RESULT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h14;
	// adc_control_one fields
	localparam int CTRL_ON = 15;
	localparam int CTRL_SRC_LO = 5;
	localparam int CTRL_SRC_HI = 7;
	localparam int CTRL_STOP = 4;
	localparam int CTRL_AUTO = 2;
	localparam int CTRL_SAMPLE_FLAG = 1;
	localparam int CTRL_DONE = 0;
	// Sequence register fields
	localparam int SEQ_CNT_LO = 0;
	localparam int SEQ_CNT_HI = 3;
	localparam int SEQ_SAMC_LO = 8;
	localparam int SEQ_SAMC_HI = 12;
	// Event bits
	localparam int EVT_SEQ = 0;
	localparam int EVT_CONV = 1;
	// Trigger sources
	localparam logic [2:0] SRC_MANUAL = 3'h0;
	localparam logic [2:0] SRC_AUTO = 3'h7;
	// Reset values
	localparam logic [2:0] RST_SRC = 3'h0;
	localparam logic [3:0] RST_SEQ_CNT = 4'h0;
	localparam logic [4:0] RST_SAMC = 5'h01;
	localparam logic [EVT_W-1:0] RST_EVT = 2'h0;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SAMPLE = 3'b010,
		ST_CONVERT = 3'b100
	} adcs_state_type;
endpackage : adcs_pkg
`default_nettype wire

// >>> adcs_top.sv
// Decided for this implementation: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adcs_top import adcs_pkg::*; (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic shs_sample,
	output logic conv_start,
	input wire logic conv_done,
	input wire logic [RES_W-1:0] conv_result,
	input wire logic hw_trigger
);
	adcs_irq_if irq_bus ();

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		hit = (a == off);
	endfunction : hit

	// Bus decode
	logic access;
	logic wr_en;
	logic mapped;
	logic wr_ctrl;
	logic wr_seq;
	logic sel_ctrl;
	logic sel_seq;
	logic sel_result;
	logic sel_status;
	logic sel_clear;
	logic sel_enable;

	// One select per register, shared by write strobes, error flag and read mux
	assign sel_ctrl = hit(paddr, OFF_CTRL);
	assign sel_seq = hit(paddr, OFF_SEQ);
	assign sel_result = hit(paddr, OFF_RESULT);
	assign sel_status = hit(paddr, OFF_STATUS);
	assign sel_clear = hit(paddr, OFF_CLEAR);
	assign sel_enable = hit(paddr, OFF_ENABLE);

	assign access = psel && penable;
	assign wr_en = access && pwrite && ce;
	assign mapped = sel_ctrl || sel_seq || sel_result || sel_status || sel_clear || sel_enable;
	assign wr_ctrl = wr_en && sel_ctrl;
	assign wr_seq = wr_en && sel_seq;
	assign pready = access;
	assign pslverr = access && !mapped;

	// Control fields
	logic mod_on;
	logic [2:0] trig_src;
	logic stop_on_first_irq;
	logic auto_sample_start;
	logic done;
	logic [3:0] seq_len;
	logic [4:0] samc;
	logic [RES_W-1:0] result;

	// Sequencer state
	adcs_state_type state;
	adcs_state_type next_state;
	logic [4:0] sample_flag_cnt;
	logic [3:0] conv_cnt;
	logic sample_flag;
	logic launch;
	logic finish;
	logic seq_end;
	logic sw_start;
	logic sw_end;
	logic on_now;
	logic auto_now;

	assign sample_flag = (state == ST_SAMPLE);
	assign sw_start = wr_ctrl && pwdata[CTRL_SAMPLE_FLAG] && !auto_sample_start;
	assign sw_end = wr_ctrl && !pwdata[CTRL_SAMPLE_FLAG] && (trig_src == SRC_MANUAL);
	assign finish = (state == ST_CONVERT) && conv_done;
	assign seq_end = finish && (conv_cnt == seq_len);

	// A control write acts in the cycle it lands, so enable and start may share one write
	assign on_now = wr_ctrl ? pwdata[CTRL_ON] : mod_on;
	assign auto_now = wr_ctrl ? pwdata[CTRL_AUTO] : auto_sample_start;

	// Sampling ends by software or by hardware depending on the source
	always_comb begin
		launch = 1'b0;
		if (state == ST_SAMPLE) begin
			case (trig_src)
				SRC_MANUAL: launch = sw_end;
				SRC_AUTO: launch = ({1'b0, sample_flag_cnt} + 6'h01) >= {1'b0, samc};
				default: launch = hw_trigger;
			endcase
		end
	end

	always_comb begin
		next_state = state;
		if (!on_now) begin
			next_state = ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (auto_now || sw_start) begin
						next_state = ST_SAMPLE;
					end
				end
				ST_SAMPLE: begin
					if (launch) begin
						next_state = ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (finish) begin
						if (seq_end && stop_on_first_irq) begin
							next_state = ST_IDLE;
						end else if (auto_sample_start) begin
							next_state = ST_SAMPLE;
						end else begin
							next_state = ST_IDLE;
						end
					end
				end
				default: next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= ST_IDLE;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// Acquisition time counter for the internal source
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sample_flag_cnt <= 5'h00;
		end else if (ce) begin
			if (state == ST_SAMPLE && !launch) begin
				sample_flag_cnt <= sample_flag_cnt + 5'h01;
			end else begin
				sample_flag_cnt <= 5'h00;
			end
		end
	end

	// Conversions completed within the current sequence
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_cnt <= 4'h0;
		end else if (ce) begin
			if (!mod_on || seq_end) begin
				conv_cnt <= 4'h0;
			end else if (finish) begin
				conv_cnt <= conv_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv_start <= 1'b0;
		end else if (ce) begin
			conv_start <= launch && on_now;
		end
	end

	assign shs_sample = sample_flag;

	// Result is overwritten by every conversion
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			result <= '0;
		end else if (ce && finish) begin
			result <= conv_result;
		end
	end

	// Completion flag: set wins, software may only clear it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			done <= 1'b0;
		end else if (ce) begin
			if (finish) begin
				done <= 1'b1;
			end else if (launch && mod_on) begin
				done <= 1'b0;
			end else if (wr_ctrl && !pwdata[CTRL_DONE]) begin
				done <= 1'b0;
			end
		end
	end

	// Auto-sample bit, dropped by hardware at the first sequence end while the stop bit is set
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			auto_sample_start <= 1'b0;
		end else if (ce) begin
			if (seq_end && stop_on_first_irq && mod_on) begin
				auto_sample_start <= 1'b0;
			end else if (wr_ctrl) begin
				auto_sample_start <= pwdata[CTRL_AUTO];
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mod_on <= 1'b0;
			trig_src <= RST_SRC;
			stop_on_first_irq <= 1'b0;
		end else if (ce && wr_ctrl) begin
			mod_on <= pwdata[CTRL_ON];
			trig_src <= pwdata[CTRL_SRC_HI:CTRL_SRC_LO];
			stop_on_first_irq <= pwdata[CTRL_STOP];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			seq_len <= RST_SEQ_CNT;
			samc <= RST_SAMC;
		end else if (ce && wr_seq) begin
			seq_len <= pwdata[SEQ_CNT_HI:SEQ_CNT_LO];
			samc <= pwdata[SEQ_SAMC_HI:SEQ_SAMC_LO];
		end
	end

	// Interrupt unit hookup
	always_comb begin
		irq_bus.events = '0;
		irq_bus.events[EVT_SEQ] = seq_end && mod_on;
		irq_bus.events[EVT_CONV] = finish && mod_on;
		irq_bus.clr_we = wr_en && sel_clear;
		irq_bus.en_we = wr_en && sel_enable;
		irq_bus.wdata = pwdata[EVT_W-1:0];
	end

	adcs_irq_unit u_irq (
		.clk(clk),
		.arst_n(arst_n),
		.ce(ce),
		.bus(irq_bus)
	);

	assign irq = irq_bus.irq;

	// Read data captured in the setup cycle
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (sel_ctrl) begin
			rd_mux[CTRL_ON] = mod_on;
			rd_mux[CTRL_SRC_HI:CTRL_SRC_LO] = trig_src;
			rd_mux[CTRL_STOP] = stop_on_first_irq;
			rd_mux[CTRL_AUTO] = auto_sample_start;
			rd_mux[CTRL_SAMPLE_FLAG] = sample_flag;
			rd_mux[CTRL_DONE] = done;
		end else if (sel_seq) begin
			rd_mux[SEQ_CNT_HI:SEQ_CNT_LO] = seq_len;
			rd_mux[SEQ_SAMC_HI:SEQ_SAMC_LO] = samc;
		end else if (sel_result) begin
			rd_mux[RES_W-1:0] = result;
		end else if (sel_status) begin
			rd_mux[EVT_W-1:0] = irq_bus.status;
		end else if (sel_enable) begin
			rd_mux[EVT_W-1:0] = irq_bus.enable;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable) begin
			prdata <= pwrite ? 32'h0000_0000 : rd_mux;
		end
	end
endmodule : adcs_top
`default_nettype wire
